//--- core/tsp_pkg.sv
// Shared constants and types for the touch sensor host port.
// Assumes a single 50 MHz clock domain; the I2C pins arrive asynchronously.
package tsp_pkg;

  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int ACK_NORM_US = 140;
  localparam int ACK_SAVE_US = 100;
  // Longest times round down
  localparam int ACK_NORM_CYC = ACK_NORM_US * CYC_PER_US;
  localparam int ACK_SAVE_CYC = ACK_SAVE_US * CYC_PER_US;
  localparam int NV_WRITE_US = 10_000;
  localparam int NV_WRITE_CYC_DEF = NV_WRITE_US * CYC_PER_US;
  localparam int BOOT_US = 1_000;
  localparam int BOOT_CYC_DEF = BOOT_US * CYC_PER_US;
  localparam int CNT_W = 24;

  // Command space
  localparam logic [7:0] IDX_CMD = 8'h00A0;
  localparam logic [7:0] CMD_SAVE = 8'h0001;

  // Sleep interval codes
  localparam logic [1:0] SLP_512HZ = 2'h0;
  localparam logic [1:0] SLP_64HZ = 2'h1;
  localparam logic [1:0] SLP_8HZ = 2'h2;
  localparam logic [1:0] SLP_1HZ = 2'h3;

  // Sensor data
  localparam int RAW_W = 16;
  localparam int ACC_W = RAW_W + 4;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
  } tsp_i2c_st_t;

  typedef struct packed {
    logic stb;
    logic [7:0] idx;
    logic [7:0] data;
  } tsp_wr_t;

  typedef struct packed {
    logic valid;
    logic drop;
    logic [RAW_W-1:0] data;
  } tsp_smp_t;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [4:0] n;
    logic ov;
    logic [RAW_W-1:0] od;
  } tsp_avg_state_t;

  typedef struct packed {
    tsp_i2c_st_t st;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rd;
    logic first;
    logic [7:0] idx;
    logic sda_oe;
    logic busy;
    logic [CNT_W-1:0] cnt;
    logic booted;
    tsp_wr_t wr;
    logic save_ok;
    logic save_fail;
    logic bus_act;
    logic scanning;
    logic dirty;
    logic [RAW_W-1:0] base;
    logic base_ok;
    logic touch;
  } tsp_state_t;

endpackage

//--- core/tsp_avg.sv
// Averaging filter over 2, 4, 8 or 16 raw counts, with sample drop.
// Assumes samples and controls come from logic on the same clock.
module tsp_avg import tsp_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic en_in,
  input wire logic [1:0] sel_in,
  // Samples
  input tsp_smp_t smp_in,
  output logic valid_out,
  output logic [RAW_W-1:0] data_out
);

  tsp_avg_state_t q, d;
  logic [4:0] last_n;
  logic take;

  assign last_n = 5'((2 << sel_in) - 1);
  assign take = smp_in.valid & ~smp_in.drop;

  always_comb begin
    d = q;
    d.ov = 1'b0;
    if (take) begin
      if (!en_in) begin
        d.ov = 1'b1;
        d.od = smp_in.data;
        d.acc = '0;
        d.n = '0;
      end else if (q.n == last_n) begin
        // Power-of-two length, so a shift divides
        d.ov = 1'b1;
        d.od = RAW_W'((q.acc + ACC_W'(smp_in.data)) >> (3'(sel_in) + 3'd1));
        d.acc = '0;
        d.n = '0;
      end else begin
        d.acc = q.acc + ACC_W'(smp_in.data);
        d.n = q.n + 5'd1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign valid_out = q.ov;
  assign data_out = q.od;

  AST_AVG_COUNT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && take && q.n == last_n) |=> q.ov && q.n == 5'd0)
    else $error("average not emitted after the selected sample count");
  AST_AVG_SMOOTH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && $stable(sel_in) && take && q.n != last_n) |=> !q.ov)
    else $error("filtered count emitted before the window was full");

endmodule

//--- core/tsp_host_port.sv
// Host port of a capacitive touch controller: I2C slave, store sequencing,
// sample filters and baseline tracking. Assumes an external pull-up on SDA
// and a sensing core that supplies scan start pulses and raw counts.
module tsp_host_port import tsp_pkg::*; #(
  parameter int NV_WRITE_CYC = NV_WRITE_CYC_DEF,
  parameter int BOOT_CYC = BOOT_CYC_DEF
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Configuration
  input wire logic [6:0] addr_in,
  input wire logic [1:0] sleep_sel_in,
  input wire logic avg_en_in,
  input wire logic [1:0] avg_sel_in,
  input wire logic drop_en_in,
  input wire logic [RAW_W-1:0] thresh_in,
  input wire logic [RAW_W-1:0] nominal_in,
  // Register space outside the port
  output tsp_wr_t wr_out,
  output logic [7:0] rd_idx_out,
  input wire logic [7:0] rd_data_in,
  // Status
  output logic booted_out,
  output logic busy_out,
  output logic save_ok_out,
  output logic save_fail_out,
  // Sensing core
  input wire logic scan_start_in,
  input wire logic raw_valid_in,
  input wire logic [RAW_W-1:0] raw_in,
  output logic count_valid_out,
  output logic [RAW_W-1:0] count_out,
  output logic [RAW_W-1:0] baseline_out,
  output logic touch_out
);

  if (NV_WRITE_CYC < 1 || NV_WRITE_CYC >= (1 << CNT_W) ||
      BOOT_CYC < 1 || BOOT_CYC >= (1 << CNT_W)) begin : g_chk
    $error("tsp_host_port: count parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  tsp_state_t q, d;
  tsp_smp_t smp;
  logic scl_rise, scl_fall, start_c, stop_c, slow_sleep;
  logic avg_valid;
  logic [RAW_W-1:0] avg_data;

  // Store only survives the slow sleep intervals
  assign slow_sleep = (sleep_sel_in == SLP_8HZ) || (sleep_sel_in == SLP_1HZ);

  always_comb begin
    d = q;
    d.wr.stb = 1'b0;
    d.save_ok = 1'b0;
    d.save_fail = 1'b0;
    // Third stage agreeing with second counts as a change
    d.scl_s = {q.scl_s[1:0], scl_in};
    d.sda_s = {q.sda_s[1:0], sda_in};
    if (q.scl_s[2] == q.scl_s[1]) begin
      d.scl_f = q.scl_s[1];
    end
    if (q.sda_s[2] == q.sda_s[1]) begin
      d.sda_f = q.sda_s[1];
    end
    scl_rise = d.scl_f & ~q.scl_f;
    scl_fall = ~d.scl_f & q.scl_f;
    start_c = q.scl_f & d.scl_f & q.sda_f & ~d.sda_f;
    stop_c = q.scl_f & d.scl_f & ~q.sda_f & d.sda_f;

    // Boot, then store timing; one counter serves both
    if (!q.booted) begin
      d.cnt = q.cnt + 1'b1;
      if (q.cnt == CNT_W'(BOOT_CYC - 1)) begin
        d.booted = 1'b1;
        d.cnt = '0;
      end
    end else if (q.busy) begin
      d.cnt = q.cnt + 1'b1;
      if (q.cnt == CNT_W'(NV_WRITE_CYC - 1)) begin
        d.busy = 1'b0;
        d.save_ok = 1'b1;
        d.cnt = '0;
      end
    end

    // Bus is ignored until boot ends, so no stray address match
    if (!q.booted) begin
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
    end else if (start_c) begin
      d.st = ST_ADDR;
      d.bits = '0;
      d.sda_oe = 1'b0;
      d.bus_act = 1'b1;
    end else if (stop_c) begin
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
      d.bus_act = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], q.sda_f};
            d.bits = q.bits + 4'd1;
          end else if (scl_fall && q.bits == 4'd8) begin
            d.bits = '0;
            if (q.st == ST_ADDR) begin
              // Address NACKed while the store runs
              if (q.sh[7:1] == addr_in && !q.busy) begin
                d.sda_oe = 1'b1;
                d.rd = q.sh[0];
                d.first = 1'b1;
                d.st = ST_AACK;
              end else begin
                d.st = ST_IDLE;
              end
            end else begin
              d.sda_oe = 1'b1;
              d.st = ST_WACK;
              if (q.first) begin
                d.idx = q.sh;
                d.first = 1'b0;
              end else if (q.idx == IDX_CMD && q.sh == CMD_SAVE) begin
                if (slow_sleep) begin
                  d.busy = 1'b1;
                  d.cnt = '0;
                end else begin
                  d.save_fail = 1'b1;
                end
              end else if (!q.busy) begin
                d.wr.stb = 1'b1;
                d.wr.idx = q.idx;
                d.wr.data = q.sh;
                d.idx = q.idx + 8'd1;
              end
            end
          end
        end
        ST_AACK, ST_WACK: begin
          if (scl_fall) begin
            d.bits = '0;
            if (q.rd) begin
              d.sh = rd_data_in;
              d.sda_oe = ~rd_data_in[7];
              d.st = ST_RD;
            end else begin
              d.sda_oe = 1'b0;
              d.st = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            d.bits = q.bits + 4'd1;
            if (q.bits == 4'd7) begin
              d.sda_oe = 1'b0;
              d.st = ST_RACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (q.sda_f) begin
              d.st = ST_IDLE;
            end else begin
              d.idx = q.idx + 8'd1;
            end
          end else if (scl_fall) begin
            d.bits = '0;
            d.sh = rd_data_in;
            d.sda_oe = ~rd_data_in[7];
            d.st = ST_RD;
          end
        end
      endcase
    end

    // Scan overlapped by bus traffic is marked for dropping; a new scan wins
    if (raw_valid_in) begin
      d.scanning = 1'b0;
      d.dirty = 1'b0;
    end
    if (scan_start_in) begin
      d.scanning = 1'b1;
      d.dirty = q.bus_act | start_c;
    end else if (q.scanning && !raw_valid_in && (q.bus_act || start_c)) begin
      d.dirty = 1'b1;
    end

    // Baseline: seeded from the nominal count when averaging, held while touched
    if (avg_valid) begin
      if (!q.base_ok) begin
        d.base_ok = 1'b1;
        d.base = avg_en_in ? nominal_in : avg_data;
        d.touch = avg_en_in && ({1'b0, avg_data} > {1'b0, nominal_in} + {1'b0, thresh_in});
      end else begin
        d.touch = {1'b0, avg_data} > {1'b0, q.base} + {1'b0, thresh_in};
        if (!d.touch) begin
          d.base = RAW_W'((ACC_W'(q.base) * 3 + ACC_W'(avg_data)) >> 2);
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filter

  assign smp = '{valid: raw_valid_in,
                 drop: drop_en_in & (q.dirty | (q.scanning & q.bus_act)),
                 data: raw_in};

  tsp_avg u_avg (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .en_in(avg_en_in),
    .sel_in(avg_sel_in),
    .smp_in(smp),
    .valid_out(avg_valid),
    .data_out(avg_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sda_out = 1'b0;
  assign sda_oe_out = q.sda_oe;
  assign wr_out = q.wr;
  assign rd_idx_out = q.idx;
  assign booted_out = q.booted;
  assign busy_out = q.busy;
  assign save_ok_out = q.save_ok;
  assign save_fail_out = q.save_fail;
  assign count_valid_out = avg_valid;
  assign count_out = avg_data;
  assign baseline_out = q.base;
  assign touch_out = q.touch;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Cycles from the eighth clock edge of a byte to its acknowledge
  logic [CNT_W-1:0] ack_wait_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_wait_q <= '0;
    end else if ((q.st == ST_ADDR || q.st == ST_WR) && q.bits == 4'd8) begin
      ack_wait_q <= ack_wait_q + 1'b1;
    end else begin
      ack_wait_q <= '0;
    end
  end

  AST_ACK_NORM: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(q.sda_oe) && q.st != ST_RD |-> ack_wait_q <= CNT_W'(ACK_NORM_CYC))
    else $error("acknowledge later than the normal bound");
  AST_ACK_SAVE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(q.busy) |-> q.sda_oe && q.st == ST_WACK && ack_wait_q <= CNT_W'(ACK_SAVE_CYC))
    else $error("store command not acknowledged in time");
  AST_REFUSE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    q.busy |-> q.st != ST_AACK && !q.wr.stb)
    else $error("host access taken while store runs");
  AST_STORE_END: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(q.busy) |-> q.save_ok && $past(q.cnt) == CNT_W'(NV_WRITE_CYC - 1))
    else $error("store ended at the wrong count");
  AST_SAVE_FAST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    q.save_fail |-> !q.busy && !$past(slow_sleep))
    else $error("store failure flagged with a slow sleep interval");
  AST_DROP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    raw_valid_in && drop_en_in && q.dirty |=> !avg_valid)
    else $error("sample from a disturbed scan reached the filter output");
  AST_BOOT_QUIET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !q.booted |-> !q.sda_oe && q.st == ST_IDLE)
    else $error("bus driven before boot finished");
  AST_BASE_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    q.touch && q.base_ok && avg_valid &&
    {1'b0, avg_data} > {1'b0, q.base} + {1'b0, thresh_in} |=> $stable(q.base))
    else $error("baseline moved while touched");

  COV_SAVE: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(q.busy));
  COV_READ: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    q.st == ST_RACK ##1 q.st == ST_RD);
  COV_DROP: cover property (@(posedge clk_in) disable iff (!rst_n_in) raw_valid_in && smp.drop);
  COV_STUCK: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    avg_en_in && $rose(q.base_ok) ##1 q.touch);

endmodule

//--- verification/tsp_i2c_host.sv
// I2C bus master model that sits on the host side of the port.
// Assumes the bench resolves SDA with a pull-up; SCL is driven only here.
module tsp_i2c_host #(
  parameter int Q = 6
) (
  // Clock
  input wire logic clk_in,
  // Bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic hq();
    repeat (Q) @(posedge clk_in);
  endtask
  task automatic start();
    sda_low_out <= 1'b1;
    hq();
    scl_out <= 1'b0;
    hq();
  endtask
  task automatic stop();
    sda_low_out <= 1'b1;
    hq();
    scl_out <= 1'b1;
    hq();
    sda_low_out <= 1'b0;
    hq();
  endtask
  // Sample well after the port's synchroniser has settled
  task automatic bit_x(input logic b, output logic r);
    sda_low_out <= ~b;
    hq();
    scl_out <= 1'b1;
    hq();
    r = sda_in;
    hq();
    scl_out <= 1'b0;
    hq();
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(~more, r);
  endtask
endmodule

//--- verification/tsp_host_port_tb_top.sv
// Self-checking bench for the touch sensor host port.
// Assumes the I2C master model and a register space that answers idx ^ 5A.
module tsp_host_port_tb_top import tsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NVC = 400;
  localparam int BTC = 600;
  localparam logic [6:0] ADR = 7'h2B;
  logic clk_in = 1'b0;
  logic rst_n_in, scl, sda_low, sda_oe, sda_o, avg_en, drop_en, scan, rv;
  logic booted, busy, s_ok, s_fail, cv, touch, ack;
  logic [1:0] sleep_sel, avg_sel;
  logic [15:0] raw, count, base, cv_last, seed_q;
  logic [19:0] sum;
  logic [7:0] rd_idx, idx, d1, d2, b;
  tsp_wr_t wr, wr_last;
  int bad_count, compares, wr_n, cv_n, ok_n, fail_n, busy_n, boot_n, n0, f0, o0, b0, tries;
  wire logic sda_w;
  assign sda_w = ~(sda_low | sda_oe);
  always #10 clk_in = ~clk_in;
  tsp_i2c_host i_host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_low_out(sda_low));
  tsp_host_port #(.NV_WRITE_CYC(NVC), .BOOT_CYC(BTC)) i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_in(ADR), .sleep_sel_in(sleep_sel),
    .avg_en_in(avg_en), .avg_sel_in(avg_sel), .drop_en_in(drop_en),
    .thresh_in(16'h000A), .nominal_in(16'h0064), .wr_out(wr), .rd_idx_out(rd_idx),
    .rd_data_in(rd_idx ^ 8'h5A), .booted_out(booted), .busy_out(busy),
    .save_ok_out(s_ok), .save_fail_out(s_fail), .scan_start_in(scan),
    .raw_valid_in(rv), .raw_in(raw), .count_valid_out(cv), .count_out(count),
    .baseline_out(base), .touch_out(touch));
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    if (wr.stb === 1'b1) begin
      wr_n++;
      wr_last = wr;
    end
    if (cv === 1'b1) begin
      cv_n++;
      cv_last = count;
    end
    ok_n += (s_ok === 1'b1);
    fail_n += (s_fail === 1'b1);
    busy_n += (busy === 1'b1);
    boot_n += (rst_n_in === 1'b1 && booted !== 1'b1);
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic smp(input logic [15:0] v, input logic sc);
    scan <= sc;
    @(posedge clk_in);
    scan <= 1'b0;
    if (sc) begin
      i_host.start();
      i_host.stop();
    end
    raw <= v;
    rv <= 1'b1;
    @(posedge clk_in);
    rv <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic xfer(input logic [7:0] a, input logic [7:0] x, input int n);
    i_host.start();
    i_host.wr_byte(a, ack);
    if (n > 0) begin
      i_host.wr_byte(x, ack);
    end
    i_host.stop();
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n_in, avg_en, drop_en, scan, rv, sleep_sel, avg_sel} = 9'h080;
    {raw, seed_q} = 32'h0000_000A;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    xfer({ADR, 1'b0}, 8'h00, 0);
    chk("early ack", 0, ack);
    chk("sda value", 0, sda_o);
    for (int k = 0; k < 2000 && booted !== 1'b1; k++) @(posedge clk_in);
    chk("boot cycles", BTC, boot_n);
    // Finger present at power-up with averaging on; broken on purpose
    smp(16'h03E8, 0);
    smp(16'h03E8, 0);
    chk("first avg", 16'h03E8, cv_last);
    chk("touch", 1, touch);
    chk("baseline", 16'h0064, base);
    $display("test boot done");
    for (int s = 0; s < 4; s++) begin
      avg_sel <= s[1:0];
      sum = 0;
      n0 = cv_n;
      for (int k = 0; k < (2 << s); k++) begin
        seed_q = lfsr(seed_q);
        sum += seed_q;
        smp(seed_q, 0);
      end
      chk("avg pulses", 1, cv_n - n0);
      chk("avg value", sum >> (s + 1), cv_last);
    end
    avg_en <= 1'b0;
    drop_en <= 1'b1;
    n0 = cv_n;
    smp(16'h1234, 1);
    chk("dropped", n0, cv_n);
    smp(16'h2345, 0);
    chk("kept", 16'h2345, cv_last);
    drop_en <= 1'b0;
    smp(16'h3456, 1);
    chk("kept count", n0 + 2, cv_n);
    $display("test filter done");
    xfer({ADR ^ 7'h01, 1'b0}, 8'h00, 0);
    chk("wrong addr", 0, ack);
    seed_q = lfsr(seed_q);
    // Index kept below the store command index
    {idx, d1, d2} = {1'b0, seed_q[6:0], seed_q};
    n0 = wr_n;
    i_host.start();
    i_host.wr_byte({ADR, 1'b0}, ack);
    i_host.wr_byte(idx, ack);
    i_host.wr_byte(d1, ack);
    i_host.wr_byte(d2, ack);
    i_host.stop();
    chk("write ack", 1, ack);
    chk("writes", 2, wr_n - n0);
    chk("last write", {1'b1, idx + 8'h01, d2}, wr_last);
    xfer({ADR, 1'b0}, idx, 1);
    i_host.start();
    i_host.wr_byte({ADR, 1'b1}, ack);
    i_host.rd_byte(1'b1, d1);
    i_host.rd_byte(1'b0, d2);
    i_host.stop();
    chk("read 0", idx ^ 8'h5A, d1);
    chk("read 1", (idx + 8'h01) ^ 8'h5A, d2);
    $display("test access done");
    for (int c = 0; c < 4; c++) begin
      sleep_sel <= c[1:0];
      {f0, o0, b0} = {fail_n, ok_n, busy_n};
      i_host.start();
      i_host.wr_byte({ADR, 1'b0}, ack);
      i_host.wr_byte(IDX_CMD, ack);
      i_host.wr_byte(CMD_SAVE, ack);
      i_host.stop();
      chk("save ack", 1, ack);
      tries = 0;
      ack = 1'b0;
      while (ack !== 1'b1 && tries < 10) begin
        tries++;
        xfer({ADR, 1'b0}, 8'h00, 0);
      end
      chk("tries", (c < 2) ? 1 : 2, tries);
      chk("fail pulses", c < 2, fail_n - f0);
      chk("ok pulses", c >= 2, ok_n - o0);
      chk("busy cycles", (c < 2) ? 0 : NVC, busy_n - b0);
    end
    sleep_sel <= SLP_512HZ;
    $display("test store done");
    test_done();
  end
endmodule
